// ### rtl/read_pipe.sv
// Read data latency pipeline with a selectable output tap
`timescale 1ns/1ps
module read_pipe
  import sgram_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        in_valid,
  input  wire logic [31:0] in_data,
  input  wire logic [1:0]  lat,
  output logic             out_valid,
  output logic [31:0]      out_data
);

  typedef struct packed {
    logic [2:0]       v;
    logic [2:0][31:0] d;
  } pipe_type;

  pipe_type s;
  pipe_type next_s;
  logic [1:0] tap;

  // Shift one stage per cycle
  always_comb begin
    next_s   = s;
    next_s.v = {s.v[1:0], in_valid};
    next_s.d = {s.d[1:0], in_data};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Tap at latency minus one; latency zero never stored
  assign tap       = lat - 2'h1;
  assign out_valid = s.v[tap];
  assign out_data  = s.d[tap];

endmodule : read_pipe

// ### rtl/sgram_burst_core.sv
// Burst, block write and special register core of a synchronous graphics DRAM
//
// Overview of operation
// - Block write puts color into eight columns
// - Data lanes mask block write columns per lane
// - Byte mask overrides mask register bits
// - Read every clock, restarts burst after latency
// - Write every clock, restarts burst with data
// - Read after write keeps earlier data only
// - Full-page read ignores write, ends otherwise
// - Burst halt acts only in full page
// - Halted read floats after read latency
// - Halted write stops accepting same clock
// - Precharge ends burst, bank waits period
// - Precharge read data valid by latency
// - Load with bit6 set, bit5 clear: color
// - Load with bit5 set, bit6 clear: mask
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module sgram_burst_core
  import sgram_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire cmd_type     cmd_in,
  input  wire logic [31:0] data_lane_in,
  input  wire logic [3:0]  lane_byte_mask,
  output logic [31:0]      data_lane_out,
  output logic [3:0]       data_lane_oe
);

  typedef struct packed {
    state_type   st;
    logic [7:0]  col;
    logic [7:0]  left;
    logic [1:0]  pre;
    logic        per_bit_write_mask;
    logic [31:0] color;
    logic [31:0] mask;
    logic [2:0]  bl;
    logic [1:0]  lat;
    logic        refused;
    logic        ph_w;
    logic [7:0]  ph_a;
    logic [31:0] rdata;
  } ctrl_type;

  ctrl_type    s;
  ctrl_type    next_s;
  logic [31:0] mem [COLS];
  logic        rd_issue;
  logic [7:0]  issue_col;
  logic        wr_en;
  logic [7:0]  wr_col;
  logic [31:0] wr_data;
  logic        bw_en;
  logic [7:0]  bw_base;
  logic        cont;
  logic        full;
  logic        row_live;
  logic        rd_valid;
  logic [31:0] rd_data;
  logic        addr_take;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] wrap_mask(input logic [2:0] bl);
    case (bl)
      3'h0:    return 8'h00;
      3'h1:    return 8'h01;
      3'h2:    return 8'h03;
      3'h3:    return 8'h07;
      default: return 8'hFF;
    endcase
  endfunction : wrap_mask

  // Sequential order wraps inside the burst-aligned block
  function automatic logic [7:0] next_col(input logic [7:0] col, input logic [2:0] bl);
    logic [7:0] m;
    m = wrap_mask(bl);
    return (col & ~m) | ((col + 8'h01) & m);
  endfunction : next_col

  assign full      = (s.bl == BL_FULL);
  assign row_live  = (s.st == ST_ACT) || (s.st == ST_RD) || (s.st == ST_WR);
  assign addr_take = hsel && hready && htrans[1];
  assign wr_data   = merge_word(mem[wr_col], data_lane_in, s.mask, s.per_bit_write_mask, lane_byte_mask);

  // ****************************************
  // Command sequencing and register bus
  // ****************************************
  always_comb begin
    next_s    = s;
    rd_issue  = 1'b0;
    issue_col = s.col;
    wr_en     = 1'b0;
    wr_col    = s.col;
    bw_en     = 1'b0;
    bw_base   = cmd_in.addr[7:0] & 8'hF8;
    cont      = 1'b1;
    case (cmd_in.code)
      CMD_READ: begin
        if (row_live) begin
          rd_issue    = 1'b1;
          issue_col   = cmd_in.addr[7:0];
          cont        = 1'b0;
          next_s.st   = (s.bl == 3'h0) ? ST_ACT : ST_RD;
          next_s.col  = next_col(cmd_in.addr[7:0], s.bl);
          next_s.left = wrap_mask(s.bl);
        end
      end
      CMD_WRITE: begin
        if (row_live && s.st == ST_RD && full) begin
          next_s.refused = 1'b1;
        end else if (row_live) begin
          wr_en       = 1'b1;
          wr_col      = cmd_in.addr[7:0];
          cont        = 1'b0;
          next_s.st   = (s.bl == 3'h0) ? ST_ACT : ST_WR;
          next_s.col  = next_col(cmd_in.addr[7:0], s.bl);
          next_s.left = wrap_mask(s.bl);
        end
      end
      CMD_BLOCK_WRITE: begin
        if (row_live && s.st == ST_RD && full) begin
          next_s.refused = 1'b1;
        end else if (row_live) begin
          bw_en     = 1'b1;
          cont      = 1'b0;
          next_s.st = ST_ACT;
        end
      end
      CMD_BURST_HALT: begin
        // Outside full page this falls through as a plain no-operation
        if (full && (s.st == ST_RD || s.st == ST_WR)) begin
          cont      = 1'b0;
          next_s.st = ST_ACT;
        end
      end
      CMD_PRECHARGE: begin
        cont       = 1'b0;
        next_s.st  = ST_PRE;
        next_s.pre = 2'(ROW_PRE_CYC - 1);
      end
      CMD_ROW_OPEN, CMD_ROW_OPEN_MSK: begin
        // Reopen refused until the precharge period has run out
        if (s.st == ST_IDLE) begin
          next_s.st  = ST_ACT;
          next_s.per_bit_write_mask = (cmd_in.code == CMD_ROW_OPEN_MSK);
        end
      end
      CMD_SPECIAL_LOAD: begin
        if (cmd_in.addr[COLOR_SEL] && !cmd_in.addr[MASK_SEL]) begin
          next_s.color = data_lane_in;
        end
        if (cmd_in.addr[MASK_SEL] && !cmd_in.addr[COLOR_SEL]) begin
          next_s.mask = data_lane_in;
        end
      end
      default: begin
      end
    endcase

    // Running burst advances one column per clock
    if (cont) begin
      case (s.st)
        ST_RD, ST_WR: begin
          rd_issue   = (s.st == ST_RD);
          wr_en      = (s.st == ST_WR);
          next_s.col = next_col(s.col, s.bl);
          if (!full) begin
            next_s.left = s.left - 8'h01;
            if (s.left == 8'h01) begin
              next_s.st = ST_ACT;
            end
          end
        end
        ST_PRE: begin
          next_s.pre = s.pre - 2'h1;
          if (s.pre == 2'h0) begin
            next_s.st = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end

    // Register bus: zero wait, data phase write, read data staged at address phase
    next_s.ph_w = addr_take && hwrite;
    next_s.ph_a = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
    if (addr_take && !hwrite) begin
      case (next_s.ph_a)
        MODE_OFS:   next_s.rdata = {26'h000_0000, s.lat, 1'b0, s.bl};
        STATUS_OFS: next_s.rdata = {22'h00_0000, s.per_bit_write_mask, s.refused, 3'h0, s.st};
        COLOR_OFS:  next_s.rdata = s.color;
        MASK_OFS:   next_s.rdata = s.mask;
        default:    next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (s.ph_w && s.ph_a == MODE_OFS) begin
      next_s.bl = hwdata[BL_LSB +: 3];
      // Latency zero is not a legal setting and is ignored
      if (hwdata[LAT_LSB +: 2] != 2'h0) begin
        next_s.lat = hwdata[LAT_LSB +: 2];
      end
    end
    // Refusal flag clears on write-one, a new refusal wins
    if (s.ph_w && s.ph_a == STATUS_OFS && hwdata[REFUSED_BIT] &&
        !(s.st == ST_RD && full && (cmd_in.code == CMD_WRITE || cmd_in.code == CMD_BLOCK_WRITE))) begin
      next_s.refused = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.st  <= ST_IDLE;
      s.bl  <= BL_RESET;
      s.lat <= LAT_RESET;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // ****************************************
  // Array: ordinary and block writes
  // ****************************************
  // Block write covers eight columns at once; each lane's data bits pick columns
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_col] <= wr_data;
      end
      if (bw_en) begin
        for (int k = 0; k < BLOCK_COLS; k++) begin
          mem[bw_base | 8'(k)] <= merge_word(mem[bw_base | 8'(k)], s.color, s.mask, s.per_bit_write_mask,
                                             lane_byte_mask | ~{data_lane_in[24 + k], data_lane_in[16 + k],
                                                                data_lane_in[8 + k], data_lane_in[k]});
        end
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  read_pipe u_read_pipe (
    .clk       (clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (rd_issue),
    .in_data   (mem[issue_col]),
    .lat       (s.lat),
    .out_valid (rd_valid),
    .out_data  (rd_data)
  );

  // Byte mask floats a lane in the same cycle
  assign data_lane_out = rd_data;
  assign data_lane_oe  = {4{rd_valid}} & ~lane_byte_mask;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s.rdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);

  logic [7:0] old_b0;
  logic [7:0] old_w0;
  assign old_b0 = mem[bw_base][7:0];
  assign old_w0 = mem[wr_col][7:0];

  sequence s_read_taken;
    cmd_in.code == CMD_READ && row_live && s.lat == 2'h2;
  endsequence

  sequence s_halt_full_read;
    cmd_in.code == CMD_BURST_HALT && full && s.st == ST_RD && s.lat != 2'h3;
  endsequence

  property p_block_color;
    bw_en && data_lane_in == 32'hFFFF_FFFF && lane_byte_mask == 4'h0 && !s.per_bit_write_mask
      |=> mem[$past(bw_base) | 8'h07] == $past(s.color);
  endproperty
  a_block_color: assert property (p_block_color) else $error("block write color missing");

  property p_col_mask;
    bw_en && !data_lane_in[0] |=> mem[$past(bw_base)][7:0] == $past(old_b0);
  endproperty
  a_col_mask: assert property (p_col_mask) else $error("masked column was written");

  property p_byte_mask;
    wr_en && lane_byte_mask[0] |=> mem[$past(wr_col)][7:0] == $past(old_w0);
  endproperty
  a_byte_mask: assert property (p_byte_mask) else $error("byte mask ignored");

  property p_read_latency;
    s_read_taken ##0 (cmd_in.code != CMD_PRECHARGE) |-> ##2 rd_valid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data late");

  property p_write_restart;
    cmd_in.code == CMD_WRITE && s.st == ST_WR |-> wr_en && wr_col == cmd_in.addr[7:0];
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("write did not restart");

  property p_read_after_write;
    cmd_in.code == CMD_READ && s.st == ST_WR |-> !wr_en;
  endproperty
  a_read_after_write: assert property (p_read_after_write) else $error("write on read clock");

  property p_full_read_keeps;
    cmd_in.code == CMD_WRITE && s.st == ST_RD && full |=> s.st == ST_RD && s.refused;
  endproperty
  a_full_read_keeps: assert property (p_full_read_keeps) else $error("full page read broken");

  property p_halt_nop;
    cmd_in.code == CMD_BURST_HALT && !full && s.st == ST_RD && s.left > 8'h01 |=> s.st == ST_RD;
  endproperty
  a_halt_nop: assert property (p_halt_nop) else $error("halt acted outside full page");

  property p_halt_read_float;
    s_halt_full_read ##1 (cmd_in.code != CMD_READ) |-> ##1 !rd_valid;
  endproperty
  a_halt_read_float: assert property (p_halt_read_float) else $error("bus not floated");

  property p_halt_write;
    cmd_in.code == CMD_BURST_HALT && full && s.st == ST_WR |-> !wr_en;
  endproperty
  a_halt_write: assert property (p_halt_write) else $error("data taken on halt");

  property p_precharge;
    cmd_in.code == CMD_PRECHARGE |=> (s.st == ST_PRE)[*3] ##1 s.st == ST_IDLE;
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge period wrong");

  property p_color_load;
    cmd_in.code == CMD_SPECIAL_LOAD && cmd_in.addr[6:5] == 2'h2 |=> s.color == $past(data_lane_in);
  endproperty
  a_color_load: assert property (p_color_load) else $error("color not loaded");

  property p_mask_load;
    cmd_in.code == CMD_SPECIAL_LOAD && cmd_in.addr[6:5] == 2'h1 |=> s.mask == $past(data_lane_in);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

endmodule : sgram_burst_core

// ### rtl/sgram_pkg.sv
// Shared constants, commands, states and carriers for the graphics DRAM burst core
package sgram_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_PRE_NS    = 30;                                      // Precharge period
  localparam int ROW_PRE_CYC   = (ROW_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] MODE_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] COLOR_OFS    = 8'h08;
  localparam logic [7:0] MASK_OFS     = 8'h0C;
  localparam int         BL_LSB       = 0;
  localparam int         LAT_LSB      = 4;
  localparam int         REFUSED_BIT  = 8;
  localparam int         WPB_BIT      = 9;
  localparam logic [2:0] BL_RESET     = 3'h0;
  localparam logic [1:0] LAT_RESET    = 2'h1;
  localparam logic [2:0] BL_FULL      = 3'h7;
  localparam int         COLOR_SEL    = 6;                                // Address bit picking color
  localparam int         MASK_SEL     = 5;                                // Address bit picking mask
  localparam int         BLOCK_COLS   = 8;
  localparam int         COLS         = 256;

  // ****************************************
  // Commands, states, carriers
  // ****************************************
  typedef enum logic [3:0] {
    CMD_NOP          = 4'h0,
    CMD_ROW_OPEN     = 4'h1,
    CMD_ROW_OPEN_MSK = 4'h2,
    CMD_READ         = 4'h3,
    CMD_WRITE        = 4'h4,
    CMD_BLOCK_WRITE  = 4'h5,
    CMD_BURST_HALT   = 4'h6,
    CMD_PRECHARGE    = 4'h7,
    CMD_SPECIAL_LOAD = 4'h8
  } cmd_code_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACT  = 5'h02,
    ST_RD   = 5'h04,
    ST_WR   = 5'h08,
    ST_PRE  = 5'h10
  } state_type;

  typedef struct packed {
    cmd_code_type code;
    logic [9:0]   addr;
  } cmd_type;

  // Bit writes where lane not byte-masked and, with per-bit masking on, mask bit set
  function automatic logic [31:0] merge_word(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [31:0] mask, input logic wpb_on,
                                             input logic [3:0] bmask);
    logic [31:0] en;
    en = {{8{~bmask[3]}}, {8{~bmask[2]}}, {8{~bmask[1]}}, {8{~bmask[0]}}} & (wpb_on ? mask : 32'hFFFF_FFFF);
    return (old_w & ~en) | (new_w & en);
  endfunction : merge_word

endpackage : sgram_pkg

// ### testbench/sgram_burst_core_tb.sv
// Self-checking bench for the graphics DRAM burst core
`timescale 1ns/1ps
module sgram_burst_core_tb;
  import sgram_pkg::*;
  logic        clk, rst_n, clk_en, hsel, hwrite, hreadyout, hresp, watch;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lane_byte_mask, data_lane_oe, bm;
  logic [31:0] haddr, hwdata, hrdata, data_lane_in, data_lane_out;
  logic [31:0] color, wmask, cmask, rd, w, fill[8];
  logic [31:0] exp_q[$];
  cmd_type     cmd_in;
  int          mismatches, compares, seed, k, j;

  sgram_burst_core dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd_in(cmd_in),
    .data_lane_in(data_lane_in), .lane_byte_mask(lane_byte_mask),
    .data_lane_out(data_lane_out), .data_lane_oe(data_lane_oe));

  sgram_ctl_model ctl (.clk(clk), .cmd_in(cmd_in), .data_lane_in(data_lane_in),
    .lane_byte_mask(lane_byte_mask));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Single AHB-Lite transfer; waits are bounded and a hang ends the run
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rv);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) n = 40;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    rv = hrdata;
    hsel <= 1'b0;
    if (n >= 40) begin
      mismatches++;
      wrap_up();
    end
  endtask : ahb

  task automatic ahb_rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    check("register read", exp, v);
    check("bus response", 32'h0000_0000, {31'h0, hresp});
  endtask : ahb_rd

  // Read words are compared in order against the noted expectations
  always @(negedge clk) begin
    if (watch && data_lane_oe !== 4'h0) begin
      if (exp_q.size() == 0)
        check("spare read word", 32'h0000_0000, {28'h0, data_lane_oe});
      else begin
        check("read word", exp_q.pop_front(), data_lane_out);
        check("lane enable", 32'h0000_000F, {28'h0, data_lane_oe});
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 88258; rst_n = 1'b0; clk_en = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; watch = 1'b0; mismatches = 0; compares = 0;
    repeat (8) @(posedge clk);
    check("enable in reset", 32'h0000_0000, {28'h0, data_lane_oe});
    rst_n <= 1'b1;
    ahb_rd(32'h0000_0000 | MODE_OFS, 32'h0000_0010);
    ahb_rd(32'h0000_0000 | STATUS_OFS, 32'h0000_0001);
    ahb_rd(32'h0000_0020, 32'h0000_0000);
    // Color and mask loads, selected by the two address bits
    color = $random(seed);
    wmask = $random(seed);
    cmask = $random(seed) & 32'hFFFF_FFFE;
    ctl.issue(CMD_SPECIAL_LOAD, 10'h040, color, 4'h0);
    ctl.issue(CMD_SPECIAL_LOAD, 10'h020, wmask, 4'h0);
    ctl.nop(1, 4'h0);
    ahb_rd(32'h0000_0000 | COLOR_OFS, color);
    ahb_rd(32'h0000_0000 | MASK_OFS, wmask);
    // Known contents in columns 8 to 15, burst of eight, latency two
    ahb(1'b1, 32'h0000_0000 | MODE_OFS, 32'h0000_0023, rd);
    ahb_rd(32'h0000_0000 | MODE_OFS, 32'h0000_0023);
    ctl.issue(CMD_ROW_OPEN, 10'h000, 32'h0, 4'h0);
    for (k = 0; k < 8; k++) fill[k] = $random(seed);
    ctl.issue(CMD_WRITE, 10'h008, fill[0], 4'h0);
    for (k = 1; k < 8; k++) ctl.beat(fill[k]);
    ctl.issue(CMD_PRECHARGE, 10'h000, 32'h0, 4'h0);
    ctl.issue(CMD_ROW_OPEN_MSK, 10'h000, 32'h0, 4'h0);
    ctl.nop(1, 4'h0);
    ahb_rd(32'h0000_0000 | STATUS_OFS, 32'h0000_0202);
    // Block write from an unaligned column, one lane byte-masked
    bm = 4'b0100;
    ctl.issue(CMD_BLOCK_WRITE, 10'h00D, cmask, bm);
    for (k = 0; k < 8; k++) begin
      w = fill[k];
      for (j = 0; j < 4; j++)
        if (cmask[j*8+k] && !bm[j])
          w[j*8+:8] = (w[j*8+:8] & ~wmask[j*8+:8]) | (color[j*8+:8] & wmask[j*8+:8]);
      exp_q.push_back(w);
    end
    // Halt inside a burst of eight must not cut it short
    watch = 1'b1;
    ctl.issue(CMD_READ, 10'h008, 32'h0, 4'h0);
    ctl.nop(2, 4'h0);
    ctl.issue(CMD_BURST_HALT, 10'h000, 32'h0, 4'h0);
    ctl.nop(10, 4'h0);
    watch = 1'b0;
    check("words left", 32'h0000_0000, exp_q.size());
    // Full page, latency one: a write is refused, a halt floats the lanes
    ahb(1'b1, 32'h0000_0000 | MODE_OFS, 32'h0000_0017, rd);
    ctl.issue(CMD_READ, 10'h008, 32'h0, 4'h0);
    ctl.issue(CMD_WRITE, 10'h008, ~fill[0], 4'h0);
    ctl.nop(1, 4'h0);
    @(negedge clk);
    check("read on past write", 32'h0000_000F, {28'h0, data_lane_oe});
    ctl.issue(CMD_BURST_HALT, 10'h000, 32'h0, 4'h0);
    ctl.nop(2, 4'h0);
    repeat (4) begin
      @(negedge clk);
      check("enable after halt", 32'h0000_0000, {28'h0, data_lane_oe});
    end
    ahb(1'b0, 32'h0000_0000 | STATUS_OFS, 32'h0, rd);
    check("refused flag", 32'h0000_0100, rd & 32'h0000_0100);
    ahb(1'b1, 32'h0000_0000 | STATUS_OFS, 32'h0000_0100, rd);
    ahb(1'b0, 32'h0000_0000 | STATUS_OFS, 32'h0, rd);
    check("refused cleared", 32'h0000_0000, rd & 32'h0000_0100);
    // Unmasked row again, so plain writes store whole words; plain color block write
    ctl.issue(CMD_PRECHARGE, 10'h000, 32'h0, 4'h0);
    ctl.issue(CMD_ROW_OPEN, 10'h000, 32'h0, 4'h0);
    ctl.issue(CMD_BLOCK_WRITE, 10'h018, 32'hFFFF_FFFF, 4'h0);
    // Restarted, then halted full-page write keeps no data from the halt clock
    fill[0] = $random(seed);
    fill[1] = $random(seed);
    fill[2] = $random(seed);
    ctl.issue(CMD_WRITE, 10'h014, fill[2], 4'h0);
    ctl.beat(fill[1]);
    ctl.issue(CMD_WRITE, 10'h014, fill[0], 4'h1);
    ctl.issue(CMD_BURST_HALT, 10'h000, ~fill[1], 4'h0);
    ctl.issue(CMD_BURST_HALT, 10'h000, 32'h0, 4'h0);
    ctl.nop(1, 4'h0);
    ahb(1'b1, 32'h0000_0000 | MODE_OFS, 32'h0000_0031, rd);
    exp_q.push_back({fill[0][31:8], fill[2][7:0]});
    exp_q.push_back(fill[1]);
    exp_q.push_back(fill[2]);
    exp_q.push_back(fill[1]);
    watch = 1'b1;
    ctl.issue(CMD_READ, 10'h014, 32'h0, 4'h0);
    ctl.nop(6, 4'h0);
    // Read cuts a write burst of two: only the first word is stored
    ctl.issue(CMD_WRITE, 10'h014, fill[2], 4'h0);
    ctl.issue(CMD_READ, 10'h014, 32'h0, 4'h0);
    ctl.nop(6, 4'h0);
    watch = 1'b0;
    check("words left", 32'h0000_0000, exp_q.size());
    wrap_up();
  end
endmodule : sgram_burst_core_tb

// ### testbench/sgram_ctl_model.sv
// Memory controller model driving the command link of the burst core
`timescale 1ns/1ps
module sgram_ctl_model
  import sgram_pkg::*;
#(
  parameter int RCD_CYC = 3,
  parameter int RSC_CYC = 2,
  parameter int BWC_CYC = 2
)(
  input  wire logic  clk,
  output cmd_type     cmd_in,
  output logic [31:0] data_lane_in,
  output logic [3:0]  lane_byte_mask
);
  int age[9];

  // Idle link at time zero, all commands long past
  initial begin
    cmd_in         = '{CMD_NOP, 10'h000};
    data_lane_in   = 32'h5A5A_A5A5;
    lane_byte_mask = 4'h0;
    foreach (age[i]) age[i] = 99;
  end

  // One clock of the link; ages count edges since each command
  task automatic step(input cmd_code_type code, input logic [9:0] addr, input logic [31:0] d,
                      input logic [3:0] bm);
    @(posedge clk);
    cmd_in         <= '{code, addr};
    data_lane_in   <= d;
    lane_byte_mask <= bm;
    foreach (age[i]) age[i]++;
    age[code] = 0;
  endtask : step

  // Released data lines toggle so a stale value is never mistaken for data
  task automatic nop(input int n, input logic [3:0] bm);
    repeat (n) step(CMD_NOP, 10'h000, ~data_lane_in, bm);
  endtask : nop

  task automatic beat(input logic [31:0] d);
    step(CMD_NOP, 10'h000, d, 4'h0);
  endtask : beat

  // Spacing is enforced here, conservatively, rather than trusted to the caller
  task automatic issue(input cmd_code_type code, input logic [9:0] addr, input logic [31:0] d,
                       input logic [3:0] bm);
    if (code == CMD_ROW_OPEN || code == CMD_ROW_OPEN_MSK)
      while (age[CMD_SPECIAL_LOAD] <= RSC_CYC || age[CMD_PRECHARGE] <= ROW_PRE_CYC) nop(1, 4'h0);
    if (code inside {CMD_READ, CMD_WRITE, CMD_BLOCK_WRITE})
      while (age[CMD_ROW_OPEN] <= RCD_CYC || age[CMD_ROW_OPEN_MSK] <= RCD_CYC ||
             age[CMD_BLOCK_WRITE] <= BWC_CYC) nop(1, 4'h0);
    if ((code == CMD_WRITE || code == CMD_BLOCK_WRITE) && age[CMD_READ] < 12)
      nop(3, 4'hF);
    // Precharge may cut a write burst, so the lanes are masked on it and the clock before
    if (code == CMD_PRECHARGE)
      nop(1, 4'hF);
    step(code, addr, d, (code == CMD_PRECHARGE) ? 4'hF : bm);
  endtask : issue
endmodule : sgram_ctl_model
